// >>> shared/fps_map.svh
// offsets, field positions, command codes and timing figures of the status poller
// assumes inclusion by bare name from the package and the design modules
`ifndef FPS_MAP_SVH
`define FPS_MAP_SVH

// ----------------------------------------
// widths of the flash pins
// ----------------------------------------
`define FPS_ADDR_W          23
`define FPS_DQ_W            16

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define FPS_REG_CTRL        8'h00
`define FPS_REG_ADDR        8'h04
`define FPS_REG_EXPECT      8'h08
`define FPS_REG_STATUS      8'h0C

// ----------------------------------------
// control register fields
// ----------------------------------------
`define FPS_CTRL_START      0
`define FPS_CTRL_OP_LSB     1
`define FPS_CTRL_CLEAR      3

// ----------------------------------------
// status register fields
// ----------------------------------------
`define FPS_ST_BUSY         0
`define FPS_ST_DONE         1
`define FPS_ST_FAIL         2
`define FPS_ST_ABORT        3
`define FPS_ST_SUSP         4
`define FPS_ST_ESTART       5
`define FPS_ST_FAULTY       6
`define FPS_ST_RB           7
`define FPS_ST_BYTE_LSB     8

// ----------------------------------------
// status word bit positions on the data bus
// ----------------------------------------
`define FPS_DQ_POLL         7
`define FPS_DQ_TOGGLE       6
`define FPS_DQ_ERROR        5
`define FPS_DQ_ETIMER       3
`define FPS_DQ_ALT          2
`define FPS_DQ_ABORT        1

// ----------------------------------------
// recovery command codes and unlock addresses
// ----------------------------------------
`define FPS_CMD_RESET       8'hF0
`define FPS_CMD_UNLOCK1     8'hAA
`define FPS_CMD_UNLOCK2     8'h55
`define FPS_UNLOCK_ADDR1    23'h000555
`define FPS_UNLOCK_ADDR2    23'h0002AA

// ----------------------------------------
// bus timing in ns
// ----------------------------------------
`define FPS_CLK_PERIOD_NS   25
`define FPS_T_ACCESS_NS     100
`define FPS_T_WPULSE_NS     50
`define FPS_T_RECOVER_NS    25

`endif

// >>> shared/fps_pkg.sv
// types shared by the status poller and its bus cycle engine
// assumes fps_map.svh is on the include path
`include "fps_map.svh"

package fps_pkg;

  typedef enum logic [1:0] {
    OP_PROGRAM  = 2'b00,
    OP_ERASE    = 2'b01,
    OP_BUFFERED = 2'b10
  } op_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ACT  = 2'b01,
    CYC_REC  = 2'b10
  } cyc_state_t;

  typedef enum logic [2:0] {
    P_IDLE  = 3'b000,
    P_RD1   = 3'b001,
    P_RD2   = 3'b010,
    P_EVAL  = 3'b011,
    P_RCHK1 = 3'b100,
    P_RCHK2 = 3'b101,
    P_CMD   = 3'b110
  } poll_state_t;

  typedef struct packed {
    logic                  write;
    logic [`FPS_ADDR_W-1:0] addr;
    logic [`FPS_DQ_W-1:0]   data;
  } bus_req_t;

  typedef struct packed {
    logic [`FPS_ADDR_W-1:0] addr;
    logic                  ce_n;
    logic                  oe_n;
    logic                  we_n;
    logic [`FPS_DQ_W-1:0]   dq_out;
    logic                  dq_oe;
  } flash_pins_t;

endpackage

// >>> hdl/fps_bus_cycle.sv
// one asynchronous flash read or write cycle per request, pins from flops
// assumes requests only arrive while o_idle is high
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_bus_cycle #(
  parameter int RD_CYC  = 4,
  parameter int WR_CYC  = 2,
  parameter int REC_CYC = 1
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_req,
  input  wire fps_pkg::bus_req_t     i_cmd,
  input  wire logic [`FPS_DQ_W-1:0]  i_dq,
  output fps_pkg::flash_pins_t       o_pins,
  output logic [`FPS_DQ_W-1:0]       o_rdata,
  output logic                       o_done,
  output logic                       o_idle
);

  typedef struct packed {
    fps_pkg::cyc_state_t   st;
    logic [7:0]            cnt;
    logic                  wr;
    fps_pkg::flash_pins_t  pins;
    logic [`FPS_DQ_W-1:0]  rdata;
    logic                  done;
  } cyc_t;

  cyc_t s_reg;
  cyc_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      fps_pkg::CYC_IDLE: begin
        if (i_req) begin
          s_next.wr           = i_cmd.write;
          s_next.pins.addr    = i_cmd.addr;
          s_next.pins.ce_n    = 1'b0;
          s_next.pins.oe_n    = i_cmd.write;
          s_next.pins.we_n    = ~i_cmd.write;
          s_next.pins.dq_out  = i_cmd.data;
          s_next.pins.dq_oe   = i_cmd.write;
          s_next.cnt          = i_cmd.write ? 8'(WR_CYC - 1) : 8'(RD_CYC - 1);
          s_next.st           = fps_pkg::CYC_ACT;
        end
      end
      fps_pkg::CYC_ACT: begin
        if (s_reg.cnt == 8'h00) begin
          if (!s_reg.wr) begin
            s_next.rdata = i_dq;
          end
          // strobe trailing edge ends the access; device advances toggles here
          s_next.pins.ce_n = 1'b1;
          s_next.pins.oe_n = 1'b1;
          s_next.pins.we_n = 1'b1;
          s_next.cnt       = 8'(REC_CYC - 1);
          s_next.st        = fps_pkg::CYC_REC;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      fps_pkg::CYC_REC: begin
        // data held through recovery so the write latches cleanly
        if (s_reg.cnt == 8'h00) begin
          s_next.pins.dq_oe = 1'b0;
          s_next.done       = 1'b1;
          s_next.st         = fps_pkg::CYC_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
      default: begin
        s_next.st = fps_pkg::CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg           <= '0;
      s_reg.pins.ce_n <= 1'b1;
      s_reg.pins.oe_n <= 1'b1;
      s_reg.pins.we_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pins  = s_reg.pins;
  assign o_rdata = s_reg.rdata;
  assign o_done  = s_reg.done;
  assign o_idle  = (s_reg.st == fps_pkg::CYC_IDLE);

endmodule // fps_bus_cycle

// >>> hdl/fps_status_poller.sv
// host side status poller for a parallel program/erase flash
// assumes the flash pins are synchronous to i_core_clk; the testbench resolves the dq wire
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_status_poller #(
  parameter int RD_CYC  = (`FPS_T_ACCESS_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS,
  parameter int WR_CYC  = (`FPS_T_WPULSE_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS,
  parameter int REC_CYC = (`FPS_T_RECOVER_NS + `FPS_CLK_PERIOD_NS - 1) / `FPS_CLK_PERIOD_NS
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic [31:0]                o_reg_rdata,
  input  wire logic [`FPS_DQ_W-1:0]  i_dq,
  input  wire logic                  i_ready_busy_pin,
  output fps_pkg::flash_pins_t       o_flash,
  output logic                       o_busy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    fps_pkg::poll_state_t   st;
    fps_pkg::op_t           op;
    logic [`FPS_ADDR_W-1:0] addr;
    logic [7:0]             expect_byte;
    logic [7:0]             first;
    logic [7:0]             second;
    logic                   busy;
    logic                   done;
    logic                   fail;
    logic                   abort;
    logic                   susp;
    logic                   estart;
    logic                   faulty;
    logic                   rb;
    logic                   abort_seq;
    logic [1:0]             cmd_idx;
    logic                   req;
    fps_pkg::bus_req_t      cmd;
    logic [31:0]            rdata;
  } poll_t;

  poll_t                  s_reg;
  poll_t                  s_next;
  logic                   cyc_done;
  logic                   cyc_idle;
  logic [`FPS_DQ_W-1:0]   cyc_rdata;
  fps_pkg::flash_pins_t   cyc_pins;

  fps_bus_cycle #(
    .RD_CYC  (RD_CYC),
    .WR_CYC  (WR_CYC),
    .REC_CYC (REC_CYC)
  ) u_cycle (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_req      (s_reg.req),
    .i_cmd      (s_reg.cmd),
    .i_dq       (i_dq),
    .o_pins     (cyc_pins),
    .o_rdata    (cyc_rdata),
    .o_done     (cyc_done),
    .o_idle     (cyc_idle)
  );

  // ----------------------------------------
  // recovery command table
  // ----------------------------------------
  function automatic fps_pkg::bus_req_t cmd_entry(input logic abort_seq,
                                                  input logic [1:0] idx,
                                                  input logic [`FPS_ADDR_W-1:0] a);
    fps_pkg::bus_req_t r;
    r.write = 1'b1;
    r.addr  = a;
    r.data  = `FPS_DQ_W'(`FPS_CMD_RESET);
    if (abort_seq) begin
      if (idx == 2'h0) begin
        r.addr = `FPS_UNLOCK_ADDR1;
        r.data = `FPS_DQ_W'(`FPS_CMD_UNLOCK1);
      end else if (idx == 2'h1) begin
        r.addr = `FPS_UNLOCK_ADDR2;
        r.data = `FPS_DQ_W'(`FPS_CMD_UNLOCK2);
      end else begin
        r.addr = `FPS_UNLOCK_ADDR1;
      end
    end
    return r;
  endfunction

  function automatic fps_pkg::bus_req_t read_req(input logic [`FPS_ADDR_W-1:0] a);
    fps_pkg::bus_req_t r;
    r.write = 1'b0;
    r.addr  = a;
    r.data  = '0;
    return r;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic tog6;
    logic tog2;
    logic clr;
    tog6   = s_reg.first[`FPS_DQ_TOGGLE] ^ s_reg.second[`FPS_DQ_TOGGLE];
    tog2   = s_reg.first[`FPS_DQ_ALT] ^ s_reg.second[`FPS_DQ_ALT];
    clr    = 1'b0;
    s_next = s_reg;
    s_next.req = 1'b0;
    s_next.rb  = i_ready_busy_pin;
    s_next.rdata = '0;

    // register port; clear happens first so a same-cycle event still lands
    if (i_reg_wr) begin
      if (i_reg_addr == `FPS_REG_CTRL) begin
        clr = i_reg_wdata[`FPS_CTRL_CLEAR];
        if (i_reg_wdata[`FPS_CTRL_START] && !s_reg.busy) begin
          clr            = 1'b1;
          s_next.op      = fps_pkg::op_t'(i_reg_wdata[`FPS_CTRL_OP_LSB +: 2]);
          s_next.busy    = 1'b1;
          s_next.req     = 1'b1;
          s_next.cmd     = read_req(s_reg.addr);
          s_next.st      = fps_pkg::P_RD1;
        end
      end else if (i_reg_addr == `FPS_REG_ADDR) begin
        if (!s_reg.busy) begin
          s_next.addr = i_reg_wdata[`FPS_ADDR_W-1:0];
        end
      end else if (i_reg_addr == `FPS_REG_EXPECT) begin
        if (!s_reg.busy) begin
          s_next.expect_byte = i_reg_wdata[7:0];
        end
      end
    end
    if (clr) begin
      s_next.done   = 1'b0;
      s_next.fail   = 1'b0;
      s_next.abort  = 1'b0;
      s_next.susp   = 1'b0;
      s_next.estart = 1'b0;
      s_next.faulty = 1'b0;
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `FPS_REG_CTRL) begin
        s_next.rdata[`FPS_CTRL_OP_LSB +: 2] = s_reg.op;
      end else if (i_reg_addr == `FPS_REG_ADDR) begin
        s_next.rdata[`FPS_ADDR_W-1:0] = s_reg.addr;
      end else if (i_reg_addr == `FPS_REG_EXPECT) begin
        s_next.rdata[7:0] = s_reg.expect_byte;
      end else if (i_reg_addr == `FPS_REG_STATUS) begin
        s_next.rdata[`FPS_ST_BUSY]   = s_reg.busy;
        s_next.rdata[`FPS_ST_DONE]   = s_reg.done;
        s_next.rdata[`FPS_ST_FAIL]   = s_reg.fail;
        s_next.rdata[`FPS_ST_ABORT]  = s_reg.abort;
        s_next.rdata[`FPS_ST_SUSP]   = s_reg.susp;
        s_next.rdata[`FPS_ST_ESTART] = s_reg.estart;
        s_next.rdata[`FPS_ST_FAULTY] = s_reg.faulty;
        s_next.rdata[`FPS_ST_RB]     = s_reg.rb;
        s_next.rdata[`FPS_ST_BYTE_LSB +: 8] = s_reg.second;
      end
    end

    // ----------------------------------------
    // polling sequence
    // ----------------------------------------
    case (s_reg.st)
      fps_pkg::P_IDLE: begin
      end
      fps_pkg::P_RD1, fps_pkg::P_RCHK1: begin
        if (cyc_done) begin
          s_next.first = cyc_rdata[7:0];
          s_next.req   = 1'b1;
          s_next.cmd   = read_req(s_reg.addr);
          s_next.st    = (s_reg.st == fps_pkg::P_RD1) ? fps_pkg::P_RD2 : fps_pkg::P_RCHK2;
        end
      end
      fps_pkg::P_RD2: begin
        if (cyc_done) begin
          s_next.second = cyc_rdata[7:0];
          s_next.st     = fps_pkg::P_EVAL;
        end
      end
      fps_pkg::P_EVAL: begin
        // bit 3 only means something for erase
        if (s_reg.op == fps_pkg::OP_ERASE) begin
          s_next.estart = s_reg.second[`FPS_DQ_ETIMER];
        end
        if (!tog6) begin
          // a steady bit 6 is either read mode or a settled suspend
          if (s_reg.op == fps_pkg::OP_ERASE && tog2 && s_reg.second[`FPS_DQ_POLL]) begin
            s_next.susp = 1'b1;
          end else if (s_reg.op != fps_pkg::OP_ERASE &&
                       s_reg.second[`FPS_DQ_POLL] != s_reg.expect_byte[`FPS_DQ_POLL]) begin
            s_next.fail = 1'b1;
          end else begin
            s_next.done = 1'b1;
          end
          s_next.busy = 1'b0;
          s_next.st   = fps_pkg::P_IDLE;
        end else if (s_reg.op == fps_pkg::OP_BUFFERED && s_reg.second[`FPS_DQ_ABORT]) begin
          s_next.abort     = 1'b1;
          s_next.abort_seq = 1'b1;
          s_next.cmd_idx   = 2'h0;
          s_next.req       = 1'b1;
          s_next.cmd       = cmd_entry(1'b1, 2'h0, s_reg.addr);
          s_next.st        = fps_pkg::P_CMD;
        end else if (s_reg.second[`FPS_DQ_ERROR]) begin
          // error may have landed just as the operation finished: look twice more
          s_next.req = 1'b1;
          s_next.cmd = read_req(s_reg.addr);
          s_next.st  = fps_pkg::P_RCHK1;
        end else begin
          // still running: last read becomes the reference for the next one
          s_next.first = s_reg.second;
          s_next.req   = 1'b1;
          s_next.cmd   = read_req(s_reg.addr);
          s_next.st    = fps_pkg::P_RD2;
        end
      end
      fps_pkg::P_RCHK2: begin
        if (cyc_done) begin
          s_next.second = cyc_rdata[7:0];
          if ((s_reg.first[`FPS_DQ_TOGGLE] ^ cyc_rdata[`FPS_DQ_TOGGLE]) == 1'b0) begin
            s_next.done = 1'b1;
            s_next.busy = 1'b0;
            s_next.st   = fps_pkg::P_IDLE;
          end else begin
            s_next.fail = 1'b1;
            if (s_reg.op == fps_pkg::OP_ERASE) begin
              s_next.faulty = s_reg.first[`FPS_DQ_ALT] ^ cyc_rdata[`FPS_DQ_ALT];
            end
            s_next.abort_seq = 1'b0;
            s_next.cmd_idx   = 2'h0;
            s_next.req       = 1'b1;
            s_next.cmd       = cmd_entry(1'b0, 2'h0, s_reg.addr);
            s_next.st        = fps_pkg::P_CMD;
          end
        end
      end
      fps_pkg::P_CMD: begin
        if (cyc_done) begin
          if (!s_reg.abort_seq || s_reg.cmd_idx == 2'h2) begin
            s_next.busy = 1'b0;
            s_next.st   = fps_pkg::P_IDLE;
          end else begin
            s_next.cmd_idx = s_reg.cmd_idx + 2'h1;
            s_next.req     = 1'b1;
            s_next.cmd     = cmd_entry(1'b1, s_reg.cmd_idx + 2'h1, s_reg.addr);
          end
        end
      end
      default: begin
        s_next.st = fps_pkg::P_IDLE;
      end
    endcase
    // the engine only takes a request while idle; every request but the start one follows a done
    s_next.req = s_next.req & (cyc_idle | cyc_done);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_reg_rdata = s_reg.rdata;
  assign o_busy      = s_reg.busy;
  assign o_flash     = cyc_pins;

endmodule // fps_status_poller

// >>> sim/fps_status_poller_props.sv
// assertions on the poller's register port and flash bus cycles
// assumes binding to fps_status_poller, seeing only its ports
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_status_poller_props #(
  parameter int RD_CYC  = 4,
  parameter int WR_CYC  = 2,
  parameter int REC_CYC = 1
) (
  input wire logic                 i_core_clk,
  input wire logic                 i_rst_n,
  input wire logic [7:0]           i_reg_addr,
  input wire logic [31:0]          i_reg_wdata,
  input wire logic                 i_reg_wr,
  input wire logic                 i_reg_rd,
  input wire logic [31:0]          o_reg_rdata,
  input wire logic [`FPS_DQ_W-1:0] i_dq,
  input wire logic                 i_ready_busy_pin,
  input wire fps_pkg::flash_pins_t o_flash,
  input wire logic                 o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [`FPS_ADDR_W-1:0] pa;
  logic                   err_seen;
  logic                   ab_seen;
  logic [3:0]             lo_cnt;
  logic                   start;
  assign start = i_reg_wr && i_reg_addr == `FPS_REG_CTRL && i_reg_wdata[0];
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  // flags drop on the first write: only the first command after them is judged
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pa <= '0;
      err_seen <= 1'b0;
      ab_seen <= 1'b0;
      lo_cnt <= 4'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == `FPS_REG_ADDR && !o_busy) pa <= i_reg_wdata[22:0];
      lo_cnt <= o_flash.oe_n ? 4'h0 : lo_cnt + 4'h1;
      if (start || !o_flash.we_n) begin
        err_seen <= 1'b0;
        ab_seen <= 1'b0;
      end else if (!o_flash.oe_n) begin
        if (i_dq[5]) err_seen <= 1'b1;
        if (i_dq[1] && !i_ready_busy_pin) ab_seen <= 1'b1;
      end
    end
  end
  sequence s_cmd_begin(flag);
    flag && $fell(o_flash.we_n);
  endsequence
  a_read_len: assert property ($rose(o_flash.oe_n) |-> int'(lo_cnt) == RD_CYC)
    else $error("read strobe length wrong");
  a_poll_addr: assert property ($fell(o_flash.oe_n) |-> o_flash.addr == pa)
    else $error("status read at wrong address");
  a_err_reset: assert property (s_cmd_begin(err_seen) |->
    o_flash.dq_out[7:0] == `FPS_CMD_RESET && o_flash.addr == pa)
    else $error("error not followed by return to read");
  a_abort_unlock: assert property (s_cmd_begin(ab_seen) |->
    o_flash.dq_out[7:0] == `FPS_CMD_UNLOCK1 && o_flash.addr == `FPS_UNLOCK_ADDR1)
    else $error("abort recovery does not begin with unlock");
  a_we_drive: assert property (!o_flash.we_n |-> o_flash.dq_oe && !o_flash.ce_n)
    else $error("write strobe without driven data");
  a_rd_release: assert property (!o_flash.oe_n |-> !o_flash.dq_oe && o_flash.we_n)
    else $error("poller drives data during read");
  a_rd_zero: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h10
    |-> o_reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_start_busy: assert property (start && !o_busy |=> o_busy[*2])
    else $error("start did not raise busy");
endmodule // fps_status_poller_props

bind fps_status_poller fps_status_poller_props #(.RD_CYC(RD_CYC), .WR_CYC(WR_CYC),
  .REC_CYC(REC_CYC)) u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_dq(i_dq),
  .i_ready_busy_pin(i_ready_busy_pin), .o_flash(o_flash), .o_busy(o_busy));

// >>> sim/fps_flash_model.sv
// behavioural flash: answers reads with the status word while busy
// assumes pins change only just after rising edges of i_core_clk
`timescale 1ns/1ps
`include "fps_map.svh"

module fps_flash_model (
  input  wire logic                 i_core_clk,
  input  wire fps_pkg::flash_pins_t i_pins,
  input  wire logic                 i_go,
  input  wire logic [2:0]           i_mode,
  input  wire logic [7:0]           i_data,
  input  wire logic [3:0]           i_reads,
  output logic [15:0]               o_dq,
  output logic                      o_ready_busy_pin,
  output logic [1:0]                o_n_wr,
  output logic [7:0]                o_last_wr
);
  logic        busy = 1'b0;
  logic        t6 = 1'b0;
  logic        t2 = 1'b0;
  logic        oe_q = 1'b1;
  logic        we_q = 1'b1;
  logic [3:0]  cnt = 4'h0;
  logic [15:0] last = 16'h0000;
  logic [7:0]  stat;
  logic [7:0]  arr;
  // ----------------------------------------
  // status word by mode
  // ----------------------------------------
  always_comb begin
    arr = (i_mode == 3'h1 || i_mode == 3'h4) ? 8'hFF : i_data;
    case (i_mode)
      3'h0: stat = {~i_data[7], t6, 6'h00};
      3'h1: stat = {1'b0, t6, 3'h1, t2, 2'h0};
      3'h2: stat = {1'b1, t6, 3'h0, t2, 2'h0};
      3'h3: stat = {~i_data[7], t6, 1'b1, 5'h00};
      3'h4: stat = {1'b0, t6, 3'h5, t2, 2'h0};
      default: stat = {~i_data[7], t6, 4'h0, 2'h2};
    endcase
  end
  // released bus shows the inverse of its last value, never a stale copy
  assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? {8'h00, busy ? stat : arr} : ~last;
  assign o_ready_busy_pin = !(busy && (i_mode <= 3'h1 || i_mode == 3'h5));
  always @(posedge i_core_clk) begin
    oe_q <= i_pins.oe_n;
    we_q <= i_pins.we_n;
    last <= o_dq;
    if (i_go) begin
      busy <= 1'b1;
      cnt <= i_reads;
      o_n_wr <= 2'h0;
      o_last_wr <= 8'h00;
    end else begin
      if (!oe_q && i_pins.oe_n && busy) begin
        t6 <= (i_mode == 3'h2) ? t6 : ~t6;
        t2 <= (i_mode == 3'h1 || i_mode == 3'h2 || i_mode == 3'h4) ? ~t2 : t2;
        if (i_mode <= 3'h1) begin
          cnt <= cnt - 4'h1;
          if (cnt == 4'h1) busy <= 1'b0;
        end
      end
      if (!we_q && i_pins.we_n) begin
        o_n_wr <= o_n_wr + 2'h1;
        o_last_wr <= i_pins.dq_out[7:0];
        if (i_pins.dq_out[7:0] == `FPS_CMD_RESET) busy <= 1'b0;
      end
    end
  end
endmodule // fps_flash_model

// >>> sim/flash_program_erase_status_readout_test.sv
// self-checking bench: status poller against the behavioural flash model
// assumes poller, props checker and model are compiled before this file
`timescale 1ns/1ps
`include "fps_map.svh"

module flash_program_erase_status_readout_test;
  typedef struct packed {
    logic [1:0]  op;
    logic [2:0]  mode;
    logic [7:0]  data;
    logic [7:0]  expv;
    logic [3:0]  reads;
    logic [15:0] mask;
    logic [15:0] want;
    logic [1:0]  nwr;
  } row_t;
  localparam logic [22:0] POLL_A = 23'h012340;
  localparam row_t ROWS [8] = '{
    '{2'h0, 3'h0, 8'h5A, 8'h5A, 4'h3, 16'hFF8F, 16'h5A82, 2'h0},
    '{2'h0, 3'h0, 8'h5A, 8'hDA, 4'h2, 16'h0005, 16'h0004, 2'h0},
    '{2'h2, 3'h0, 8'h81, 8'h81, 4'h4, 16'hFF8F, 16'h8182, 2'h0},
    '{2'h1, 3'h1, 8'h00, 8'h00, 4'h4, 16'hFFAF, 16'hFFA2, 2'h0},
    '{2'h1, 3'h2, 8'h00, 8'h00, 4'h1, 16'h009B, 16'h0090, 2'h0},
    '{2'h0, 3'h3, 8'h5A, 8'h5A, 4'h1, 16'h00C5, 16'h0084, 2'h1},
    '{2'h1, 3'h4, 8'h00, 8'h00, 4'h1, 16'h00C5, 16'h00C4, 2'h1},
    '{2'h2, 3'h5, 8'h81, 8'h81, 4'h1, 16'h0089, 16'h0088, 2'h3}
  };
  logic                 i_core_clk = 1'b0;
  logic                 i_rst_n = 1'b0;
  logic [7:0]           i_reg_addr = 8'h00;
  logic [31:0]          i_reg_wdata = 32'h0;
  logic                 i_reg_wr = 1'b0;
  logic                 i_reg_rd = 1'b0;
  logic                 go = 1'b0;
  logic [2:0]           mode = 3'h0;
  logic [7:0]           data = 8'h00;
  logic [3:0]           reads = 4'h1;
  logic [31:0]          o_reg_rdata;
  logic [31:0]          rd;
  logic [15:0]          m_dq;
  logic [15:0]          dq_wire;
  logic                 rb;
  logic                 o_busy;
  logic [1:0]           n_wr;
  logic [7:0]           last_wr;
  fps_pkg::flash_pins_t o_flash;
  int                   num_errors = 0;
  int                   n_compared = 0;
  int                   cycles = 0;

  always #12.5 i_core_clk = ~i_core_clk;
  assign dq_wire = o_flash.dq_oe ? o_flash.dq_out : m_dq;

  fps_status_poller u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_dq(dq_wire),
    .i_ready_busy_pin(rb), .o_flash(o_flash), .o_busy(o_busy));
  fps_flash_model u_flash (.i_core_clk(i_core_clk), .i_pins(o_flash), .i_go(go),
    .i_mode(mode), .i_data(data), .i_reads(reads), .o_dq(m_dq),
    .o_ready_busy_pin(rb), .o_n_wr(n_wr), .o_last_wr(last_wr));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  task automatic start_op(input row_t r);
    @(posedge i_core_clk);
    go <= 1'b1;
    mode <= r.mode;
    data <= r.data;
    reads <= r.reads;
    @(posedge i_core_clk);
    go <= 1'b0;
    reg_wr(`FPS_REG_ADDR, {9'h0, POLL_A});
    reg_wr(`FPS_REG_EXPECT, {24'h0, r.expv});
    reg_wr(`FPS_REG_CTRL, {28'h0, 1'b0, r.op, 1'b1});
  endtask
  task automatic wait_idle();
    #1;
    while (o_busy !== 1'b0) @(posedge i_core_clk) #1;
  endtask

  // timeout: whole run is under a thousand cycles
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check("busy in reset", {31'h0, o_busy}, 32'h0);
    check("ce_n in reset", {31'h0, o_flash.ce_n}, 32'h1);
    @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      start_op(ROWS[r]);
      wait_idle();
      reg_rd(`FPS_REG_STATUS, rd);
      check("status", {16'h0, rd[15:0] & ROWS[r].mask}, {16'h0, ROWS[r].want});
      check("writes", {30'h0, n_wr}, {30'h0, ROWS[r].nwr});
      if (ROWS[r].nwr != 2'h0) check("last cmd", {24'h0, last_wr}, {24'h0, `FPS_CMD_RESET});
    end
    reg_wr(`FPS_REG_CTRL, 32'h00000008);
    reg_rd(`FPS_REG_STATUS, rd);
    check("abort cleared", {31'h0, rd[3]}, 32'h0);
    reg_rd(8'h10, rd);
    check("unmapped", rd, 32'h0);
    start_op('{2'h1, 3'h1, 8'h00, 8'h00, 4'hC, 16'h0, 16'h0, 2'h0});
    reg_wr(`FPS_REG_ADDR, 32'h00000055);
    reg_rd(`FPS_REG_ADDR, rd);
    check("addr held", rd, {9'h0, POLL_A});
    reg_rd(`FPS_REG_STATUS, rd);
    check("busy bit", {31'h0, rd[0]}, 32'h1);
    check("rb low", {31'h0, rd[7]}, 32'h0);
    wait_idle();
    start_op('{2'h1, 3'h1, 8'h00, 8'h00, 4'hF, 16'h0, 16'h0, 2'h0});
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    @(posedge i_core_clk);
    #1;
    check("busy after reset", {31'h0, o_busy}, 32'h0);
    check("oe_n after reset", {31'h0, o_flash.oe_n}, 32'h1);
    i_rst_n <= 1'b1;
    close_out();
  end
endmodule // flash_program_erase_status_readout_test
